// ---- rtl/adc_spi_command_interface.sv ----
// serial command port, command decoder and register file of the converter
`timescale 1ns/1ps
`include "adc_spi_consts.svh"

module adc_spi_command_interface import adc_spi_pkg::*; #(
	parameter int unsigned SELF_CAL_CYCLES = `SELF_CAL_MS * `CLK_KHZ,
	parameter int unsigned SYS_CAL_CYCLES = `SYS_CAL_MS * `CLK_KHZ,
	parameter int TIMER_W = 25,
	parameter bit GAIN_ENABLE = 1'b1
) (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// serial pins
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	output logic dout,
	output logic dout_oe,
	// general purpose pins
	input wire logic [3:0] gpio_in,
	output logic [3:0] gpio_out,
	output logic [3:0] gpio_oe,
	// modulator side
	input wire logic sample_valid,
	input wire logic [15:0] sample,
	input wire logic sample_over,
	input wire logic sample_under,
	input wire logic cal_overrange,
	output logic conv_start,
	output logic [2:0] conv_rate,
	output logic cal_start,
	output logic [1:0] cal_kind,
	output logic power_down,
	// configuration to analog side
	output logic [7:0] control_register_one,
	output logic [7:0] gain_cal_control_register
);
	adc_link_if lk ();

	spi_pin_sync u_pins (
		.mclk(mclk),
		.srst(srst),
		.cs_n(cs_n),
		.sclk(sclk),
		.din(din),
		.lk(lk)
	);

	// ----------------------------------------
	// state
	// ----------------------------------------
	link_state_e st;
	logic [4:0] cnt;
	logic [4:0] len;
	logic [7:0] cmd_sh;
	logic [3:0] sel;
	word_t wsh;
	word_t out_sh;
	logic [7:0] pin_control_register;
	word_t data_reg, soc_reg, sgc_reg, scoc_reg, system_gain_correction;
	word_t chip_gain_correction;
	logic system_gain_overrange, over_range_flag, under_range_flag;
	logic modulator_busy_flag, rdy, data_taken, conv_run;
	logic [2:0] rate_stat;
	logic [TIMER_W-1:0] cal_timer;
	logic [1:0] gpio_s1, gpio_s2, gpio_s3, gpio_s4;
	logic [3:0] gpio_sync;

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	logic [7:0] next_cmd;
	logic cmd_fire, is_access, is_read;
	logic [1:0] calibration_select;
	logic power_down_now;
	logic [2:0] conversion_speed_code;
	logic [3:0] register_select;
	logic conv_cmd, cal_cmd, pd_cmd;
	logic wr_fire, rd_fire, data_read_now;
	word_t wr_word;
	logic out_msb;

	function automatic logic [4:0] reg_len(input logic [3:0] rs);
		reg_len = (rs >= `RS_DATA) ? `LEN_WIDE : `LEN_NARROW;
	endfunction

	assign next_cmd = {cmd_sh[6:0], lk.mosi};
	assign cmd_fire = lk.sck_rise && st == ST_CMD && cnt == `CMD_LAST;
	assign is_access = next_cmd[`B_MODE];
	assign is_read = next_cmd[`B_WR];
	assign register_select = next_cmd[`RS_HI:`RS_LO];
	assign calibration_select = next_cmd[`CAL_HI:`CAL_LO];
	assign power_down_now = next_cmd[`B_PD];
	assign conversion_speed_code = next_cmd[`RATE_HI:`RATE_LO];
	assign conv_cmd = cmd_fire && !is_access && calibration_select == CAL_NONE
		&& !power_down_now;
	assign pd_cmd = cmd_fire && !is_access && calibration_select == CAL_NONE
		&& power_down_now;
	assign cal_cmd = cmd_fire && !is_access && calibration_select != CAL_NONE;
	assign wr_word = {wsh[22:0], lk.mosi};
	assign wr_fire = lk.sck_rise && st == ST_WRITE && cnt == len - 5'd1;
	assign rd_fire = lk.sck_rise && st == ST_READ && cnt == len - 5'd1;
	assign data_read_now = rd_fire && sel == `RS_DATA;
	assign out_msb = out_sh[23];

	// ----------------------------------------
	// frame sequencer
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (srst || !lk.frame) begin
			st <= ST_CMD;
			cnt <= 5'd0;
			len <= `LEN_NARROW;
			cmd_sh <= 8'h00;
			sel <= `RS_STATUS;
		end else if (lk.sck_rise) begin
			case (st)
				ST_CMD: begin
					// leading zeros skipped until the start bit
					if (cnt != 5'd0 || lk.mosi) begin
						cmd_sh <= next_cmd;
						cnt <= cnt + 5'd1;
					end
					if (cmd_fire) begin
						cnt <= 5'd0;
						sel <= register_select;
						len <= reg_len(register_select);
						if (!is_access || next_cmd[`B_ZERO]) begin
							st <= ST_DONE;
						end else if (is_read) begin
							st <= ST_READ;
						end else if (register_select == `RS_STATUS
							|| register_select == `RS_DATA
							|| register_select > `RS_CHIP_GAIN_CORRECTION) begin
							st <= ST_DONE;
						end else begin
							st <= ST_WRITE;
						end
					end
				end
				ST_READ, ST_WRITE: begin
					cnt <= cnt + 5'd1;
					if (cnt == len - 5'd1) begin
						st <= ST_DONE;
					end
				end
				ST_DONE: begin
					st <= ST_DONE;
				end
				default: begin
					st <= ST_DONE;
				end
			endcase
		end
	end

	// write shifter, most significant bit first
	always_ff @(posedge mclk) begin
		if (srst || !lk.frame) begin
			wsh <= `RST_WIDE;
		end else if (lk.sck_rise && st == ST_WRITE) begin
			wsh <= wr_word;
		end
	end

	// ----------------------------------------
	// read-back and serial output
	// ----------------------------------------
	function automatic word_t read_value(input logic [3:0] rs);
		case (rs)
			`RS_STATUS: read_value = {system_gain_overrange, rate_stat, over_range_flag,
				under_range_flag, modulator_busy_flag, rdy, `NARROW_PAD};
			`RS_CONTROL_REGISTER_ONE: read_value = {control_register_one, `NARROW_PAD};
			`RS_PIN_CONTROL_REGISTER: read_value = {pin_control_register[7:4],
				(pin_control_register[7:4] & pin_control_register[3:0])
				| (~pin_control_register[7:4] & gpio_sync), `NARROW_PAD};
			`RS_GAIN_CAL_CONTROL_REGISTER: read_value = {gain_cal_control_register, `NARROW_PAD};
			`RS_DATA: read_value = data_reg;
			`RS_SOC: read_value = soc_reg;
			`RS_SGC: read_value = sgc_reg;
			`RS_SCOC: read_value = scoc_reg;
			`RS_CHIP_GAIN_CORRECTION: read_value = chip_gain_correction;
			default: read_value = `RST_WIDE;
		endcase
	endfunction

	always_ff @(posedge mclk) begin
		if (srst) begin
			out_sh <= `RST_WIDE;
			dout <= 1'b1;
			dout_oe <= 1'b0;
		end else begin
			dout_oe <= lk.frame;
			if (cmd_fire && is_access && is_read) begin
				out_sh <= read_value(register_select);
			end else if (lk.sck_fall && st == ST_READ) begin
				out_sh <= {out_sh[22:0], 1'b0};
			end
			if (!lk.frame) begin
				dout <= 1'b1;
			end else if (st == ST_READ) begin
				if (lk.sck_fall) begin
					dout <= out_msb;
				end
			end else begin
				dout <= !rdy;
			end
		end
	end

	// ----------------------------------------
	// control and coefficient registers
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			control_register_one <= `RST_CONTROL_REGISTER_ONE;
			pin_control_register <= `RST_PIN_CONTROL_REGISTER;
			gain_cal_control_register <= `RST_GAIN_CAL_CONTROL_REGISTER;
			soc_reg <= `RST_WIDE;
			sgc_reg <= `RST_WIDE;
			scoc_reg <= `RST_WIDE;
			chip_gain_correction <= `RST_WIDE;
		end else if (wr_fire) begin
			case (sel)
				`RS_CONTROL_REGISTER_ONE: control_register_one <= wr_word[7:0];
				`RS_PIN_CONTROL_REGISTER: pin_control_register <= wr_word[7:0];
				`RS_GAIN_CAL_CONTROL_REGISTER: gain_cal_control_register <= wr_word[7:0];
				`RS_SOC: soc_reg <= wr_word;
				`RS_SGC: sgc_reg <= wr_word;
				`RS_SCOC: scoc_reg <= wr_word;
				`RS_CHIP_GAIN_CORRECTION: chip_gain_correction <= wr_word;
				default: soc_reg <= soc_reg;
			endcase
		end
	end
	assign system_gain_correction = sgc_reg;

	// general pins follow the pin register
	always_ff @(posedge mclk) begin
		if (srst) begin
			gpio_out <= 4'(`RST_PIN_CONTROL_REGISTER);
			gpio_oe <= 4'h0;
			gpio_s1 <= 2'h0;
			gpio_s2 <= 2'h0;
			gpio_s3 <= 2'h0;
			gpio_s4 <= 2'h0;
		end else begin
			gpio_out <= pin_control_register[3:0];
			gpio_oe <= pin_control_register[7:4];
			gpio_s1 <= {gpio_s1[0], gpio_in[0]};
			gpio_s2 <= {gpio_s2[0], gpio_in[1]};
			gpio_s3 <= {gpio_s3[0], gpio_in[2]};
			gpio_s4 <= {gpio_s4[0], gpio_in[3]};
		end
	end
	assign gpio_sync = {gpio_s4[1], gpio_s3[1], gpio_s2[1], gpio_s1[1]};

	// ----------------------------------------
	// result formatting
	// ----------------------------------------
	logic [2:0] digital_gain_select;
	word_t scaled;
	logic pos_sat, neg_sat;
	logic [15:0] clipped, result;

	assign digital_gain_select = GAIN_ENABLE
		? gain_cal_control_register[`GAIN_HI:`GAIN_LO] : 3'h0;
	assign scaled = {{8{sample[15]}}, sample} <<< digital_gain_select;
	assign pos_sat = !scaled[23] && scaled[22:15] != `SAT_NONE;
	assign neg_sat = scaled[23] && scaled[22:15] != `SAT_ALL;
	assign clipped = pos_sat ? `POS_FULL : (neg_sat ? `RES_MSB : scaled[15:0]);
	assign result = control_register_one[`FMT_BIT]
		? (clipped ^ `RES_MSB) : clipped;

	always_ff @(posedge mclk) begin
		if (srst) begin
			data_reg <= `RST_WIDE;
			over_range_flag <= 1'b0;
			under_range_flag <= 1'b0;
		end else if (sample_valid) begin
			data_reg <= {result, `DATA_PAD};
			over_range_flag <= sample_over || pos_sat;
			under_range_flag <= sample_under || neg_sat;
		end
	end

	// ----------------------------------------
	// conversion, calibration, power
	// ----------------------------------------
	logic cal_end;
	assign cal_end = modulator_busy_flag && !conv_run && cal_timer == TIMER_W'(1);

	always_ff @(posedge mclk) begin
		if (srst) begin
			modulator_busy_flag <= 1'b0;
			conv_run <= 1'b0;
			cal_timer <= '0;
			cal_kind <= CAL_NONE;
			power_down <= 1'b0;
			conv_start <= 1'b0;
			cal_start <= 1'b0;
			conv_rate <= 3'h0;
			rate_stat <= 3'h0;
			system_gain_overrange <= 1'b0;
		end else begin
			conv_start <= conv_cmd;
			cal_start <= cal_cmd;
			if (conv_cmd) begin
				modulator_busy_flag <= 1'b1;
				conv_run <= 1'b1;
				power_down <= 1'b0;
				conv_rate <= conversion_speed_code;
				rate_stat <= conversion_speed_code;
			end else if (cal_cmd) begin
				modulator_busy_flag <= 1'b1;
				conv_run <= 1'b0;
				power_down <= 1'b0;
				cal_kind <= calibration_select;
				cal_timer <= (calibration_select == CAL_SELF)
					? TIMER_W'(SELF_CAL_CYCLES) : TIMER_W'(SYS_CAL_CYCLES);
			end else if (pd_cmd) begin
				power_down <= 1'b1;
				modulator_busy_flag <= 1'b0;
				conv_run <= 1'b0;
				cal_timer <= '0;
			end else if (conv_run && sample_valid) begin
				modulator_busy_flag <= 1'b0;
				conv_run <= 1'b0;
			end else if (cal_end) begin
				modulator_busy_flag <= 1'b0;
				cal_timer <= '0;
				if (cal_kind != CAL_SELF) begin
					system_gain_overrange <= cal_overrange;
				end
			end else if (modulator_busy_flag && !conv_run) begin
				cal_timer <= cal_timer - TIMER_W'(1);
			end
		end
	end

	// ready flag: a new result wins over any clear
	always_ff @(posedge mclk) begin
		if (srst) begin
			rdy <= 1'b0;
			data_taken <= 1'b0;
		end else begin
			if (sample_valid) begin
				rdy <= 1'b1;
			end else if (conv_cmd && (data_taken || data_read_now)) begin
				rdy <= 1'b0;
			end else if (data_read_now && conv_run) begin
				rdy <= 1'b0;
			end
			if (sample_valid) begin
				data_taken <= 1'b0;
			end else if (data_read_now) begin
				data_taken <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	a_oe_released: assert property (!lk.frame |=> !dout_oe)
		else $error("output driven outside a frame");
	a_status_level: assert property (lk.frame && st != ST_READ |=> dout == !$past(rdy))
		else $error("idle output does not show ready state");
	a_fall_only: assert property (st == ST_READ && !lk.sck_fall && lk.frame |=> $stable(dout))
		else $error("output changed without a falling edge");
	a_msb_out: assert property (st == ST_READ && lk.sck_fall |=> dout == $past(out_msb))
		else $error("output bit is not the shifter msb");
	a_busy_set: assert property (conv_cmd || cal_cmd |=> modulator_busy_flag ##1 modulator_busy_flag)
		else $error("busy flag missing after start");
	a_pd_stops: assert property (pd_cmd |=> power_down && !modulator_busy_flag && !conv_start)
		else $error("power-down did not stop the modulator");
	a_rate_taken: assert property (conv_cmd |=> conv_start && rate_stat == $past(conversion_speed_code))
		else $error("rate not recorded on conversion");
	a_rdy_set: assert property (sample_valid |=> rdy && data_reg[7:0] == `DATA_PAD)
		else $error("ready or result padding wrong after sample");
	a_rdy_kept: assert property (conv_cmd && rdy && !data_taken && !data_read_now |=> rdy)
		else $error("unread result lost its ready flag");
	a_system_gain_overrange_load: assert property (cal_end && cal_kind == CAL_SYS_GAIN |=> system_gain_overrange == $past(cal_overrange))
		else $error("gain overrange flag not updated");
endmodule

// ---- include/adc_spi_consts.svh ----
// named offsets, field positions, reset values and timing of the serial command port
`ifndef ADC_SPI_CONSTS_SVH
`define ADC_SPI_CONSTS_SVH
`define CMD_LAST 5'd7
`define B_START 7
`define B_MODE 6
`define B_ZERO 5
`define RS_HI 4
`define RS_LO 1
`define B_WR 0
`define CAL_HI 5
`define CAL_LO 4
`define B_PD 3
`define RATE_HI 2
`define RATE_LO 0
`define RS_STATUS 4'h0
`define RS_CONTROL_REGISTER_ONE 4'h1
`define RS_PIN_CONTROL_REGISTER 4'h2
`define RS_GAIN_CAL_CONTROL_REGISTER 4'h3
`define RS_DATA 4'h4
`define RS_SOC 4'h5
`define RS_SGC 4'h6
`define RS_SCOC 4'h7
`define RS_CHIP_GAIN_CORRECTION 4'h8
`define RST_STATUS 8'h00
`define RST_CONTROL_REGISTER_ONE 8'h02
`define RST_PIN_CONTROL_REGISTER 8'h0F
`define RST_GAIN_CAL_CONTROL_REGISTER 8'h1E
`define RST_WIDE 24'h000000
`define LEN_NARROW 5'd8
`define LEN_WIDE 5'd24
`define NARROW_PAD 16'h0000
`define DATA_PAD 8'h00
`define FMT_BIT 2
`define GAIN_HI 7
`define GAIN_LO 5
`define POS_FULL 16'h7FFF
`define RES_MSB 16'h8000
`define SAT_NONE 8'h00
`define SAT_ALL 8'hFF
`define CLK_KHZ 125000
`define SELF_CAL_MS 200
`define SYS_CAL_MS 100
`endif

// ---- include/adc_spi_pkg.sv ----
// types shared by the serial command port modules
package adc_spi_pkg;
	typedef enum logic [1:0] {
		ST_CMD = 2'b00,
		ST_READ = 2'b01,
		ST_WRITE = 2'b10,
		ST_DONE = 2'b11
	} link_state_e;
	typedef enum logic [1:0] {
		CAL_NONE = 2'b00,
		CAL_SELF = 2'b01,
		CAL_SYS_OFFSET = 2'b10,
		CAL_SYS_GAIN = 2'b11
	} cal_sel_e;
	typedef logic [23:0] word_t;
endpackage

// ---- include/adc_link_if.sv ----
// synchronised frame and serial clock events between pin stage and core
`timescale 1ns/1ps
interface adc_link_if;
	logic frame;
	logic sck_rise;
	logic sck_fall;
	logic mosi;
	modport front (output frame, output sck_rise, output sck_fall, output mosi);
	modport core (input frame, input sck_rise, input sck_fall, input mosi);
endinterface

// ---- rtl/spi_pin_sync.sv ----
// pin synchronisers and serial clock edge finder
`timescale 1ns/1ps
module spi_pin_sync (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// serial pins
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	// events to core
	adc_link_if.front lk
);
	logic [1:0] cs_sync;
	logic [1:0] sck_sync;
	logic [1:0] din_sync;
	logic sck_last;

	always_ff @(posedge mclk) begin
		if (srst) begin
			cs_sync <= 2'h3;
			sck_sync <= 2'h0;
			din_sync <= 2'h0;
			sck_last <= 1'b0;
		end else begin
			cs_sync <= {cs_sync[0], cs_n};
			sck_sync <= {sck_sync[0], sclk};
			din_sync <= {din_sync[0], din};
			sck_last <= sck_sync[1];
		end
	end

	// edges count only inside a frame
	assign lk.frame = !cs_sync[1];
	assign lk.sck_rise = !cs_sync[1] && sck_sync[1] && !sck_last;
	assign lk.sck_fall = !cs_sync[1] && !sck_sync[1] && sck_last;
	assign lk.mosi = din_sync[1];

	a_idle_no_edges: assert property (@(posedge mclk) disable iff (srst)
		cs_sync[1] |-> !lk.sck_rise && !lk.sck_fall)
		else $error("serial clock edge seen with chip select high");
endmodule

// ---- verif/spi_host_model.sv ----
// host controller model driving the converter's serial port
`timescale 1ns/1ps
module spi_host_model (
	// serial pins
	output logic cs_n,
	output logic sclk,
	output logic din,
	input wire logic miso,
	// results to bench
	output logic done,
	output logic [23:0] rx,
	output logic idle
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
		done = 1'b0;
		rx = 24'h000000;
		idle = 1'b0;
	end
	task automatic bit_io(input logic b, inout logic [23:0] acc);
		sclk = 1'b0;
		din = b;
		#62.5;
		sclk = 1'b1;
		acc = {acc[22:0], miso};
		#62.5;
	endtask
	task automatic xfer(input int lead, input logic [7:0] cmd, input int n,
		input logic [23:0] wd, input logic rd_en);
		logic [23:0] acc;
		acc = 24'h000000;
		cs_n = 1'b0;
		#187.5;
		idle = miso;
		for (int i = 0; i < lead; i++) bit_io(1'b0, acc);
		for (int i = 7; i >= 0; i--) bit_io(cmd[i], acc);
		for (int i = n - 1; i >= 0; i--) bit_io(rd_en ? ~din : wd[i], acc);
		sclk = 1'b0;
		#62.5;
		cs_n = 1'b1;
		// released input must not keep its last level
		din = ~din;
		rx = (n == 8) ? {16'h0000, acc[7:0]} : acc;
		done = rd_en;
		#1;
		done = 1'b0;
		#250;
	endtask
endmodule

// ---- verif/adc_spi_command_interface_bench.sv ----
// self-checking bench of the serial command port
`timescale 1ns/1ps
`include "adc_spi_consts.svh"
module adc_spi_command_interface_bench;
	import adc_spi_pkg::*;
	localparam int SELF_CYC = 2000;
	localparam int SYS_CYC = 1000;
	typedef struct {logic [23:0] val; logic idle;} note_s;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic cs_n, sclk, din, dout, dout_oe, done, idle;
	logic [23:0] rx;
	logic [3:0] gpio_in, gpio_out, gpio_oe;
	logic sample_valid, sample_over, sample_under, cal_overrange;
	logic [15:0] sample;
	logic conv_start, cal_start, power_down;
	logic [2:0] conv_rate;
	logic [1:0] cal_kind;
	logic [7:0] control_register_one_q, gain_cal_control_register_q;
	wire miso = dout_oe ? dout : 1'bz;
	int fails = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [31:0] seed = 32'h00007C78;
	logic [23:0] regs_m [9];
	logic [2:0] rate_m = 3'h0;
	logic system_gain_overrange_m = 1'b0, or_m = 1'b0, ur_m = 1'b0, busy_m = 1'b0, rdy_m = 1'b0, got_m = 1'b0;
	note_s rd_q[$];
	logic [2:0] conv_q[$];
	logic [1:0] cal_q[$];
	always #4 mclk = ~mclk;
	adc_spi_command_interface #(.SELF_CAL_CYCLES(SELF_CYC), .SYS_CAL_CYCLES(SYS_CYC))
		u_adc_spi_command_interface (.mclk(mclk), .srst(srst), .cs_n(cs_n), .sclk(sclk),
		.din(din), .dout(dout), .dout_oe(dout_oe), .gpio_in(gpio_in), .gpio_out(gpio_out),
		.gpio_oe(gpio_oe), .sample_valid(sample_valid), .sample(sample),
		.sample_over(sample_over), .sample_under(sample_under), .cal_overrange(cal_overrange),
		.conv_start(conv_start), .conv_rate(conv_rate), .cal_start(cal_start),
		.cal_kind(cal_kind), .power_down(power_down), .control_register_one(control_register_one_q),
		.gain_cal_control_register(gain_cal_control_register_q));
	spi_host_model u_spi_host_model (.cs_n(cs_n), .sclk(sclk), .din(din), .miso(miso),
		.done(done), .rx(rx), .idle(idle));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [23:0] exp_reg(input int i);
		logic [3:0] d;
		d = regs_m[2][7:4];
		if (i == 0) return {16'h0000, system_gain_overrange_m, rate_m, or_m, ur_m, busy_m, rdy_m};
		if (i == 2) return {16'h0000, d, (d & regs_m[2][3:0]) | (~d & gpio_in)};
		return regs_m[i];
	endfunction
	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic rd(input int i, input int lead = 0);
		rd_q.push_back('{exp_reg(i), ~rdy_m});
		u_spi_host_model.xfer(lead, {3'b110, 4'(i), 1'b1}, i > 3 ? 24 : 8, 24'h000000, 1'b1);
		if (i == 4) got_m = rdy_m;
	endtask
	task automatic wr(input int i, input logic [23:0] v);
		u_spi_host_model.xfer(0, {3'b110, 4'(i), 1'b0}, i > 3 ? 24 : 8, v, 1'b0);
		if (i != 0 && i != 4) regs_m[i] = i > 3 ? v : {16'h0000, v[7:0]};
	endtask
	task automatic cmd(input logic [7:0] c);
		u_spi_host_model.xfer(0, c, 0, 24'h000000, 1'b0);
		chk(24'(conv_q.size() + cal_q.size()), 24'h000000, "missing start pulse");
	endtask
	task automatic conv_done(input logic [15:0] s, input logic o, input logic u);
		logic signed [23:0] w;
		logic [15:0] r;
		@(negedge mclk);
		sample_valid = 1'b1;
		sample = s;
		sample_over = o;
		sample_under = u;
		@(negedge mclk);
		sample_valid = 1'b0;
		w = $signed(s);
		w = w <<< regs_m[3][7:5];
		r = w[15:0];
		if (w > 24'sh007FFF) begin
			r = 16'h7FFF;
			o = 1'b1;
		end
		if (w < 24'shFF8000) begin
			r = 16'h8000;
			u = 1'b1;
		end
		regs_m[4] = {r ^ {regs_m[1][2], 15'h0000}, 8'h00};
		or_m = o;
		ur_m = u;
		busy_m = 1'b0;
		rdy_m = 1'b1;
	endtask
	always @(posedge done) begin
		note_s n;
		if (rd_q.size() == 0) begin
			chk(24'h000001, 24'h000000, "stray read");
		end else begin
			n = rd_q.pop_front();
			chk(rx, n.val, "read word");
			chk(24'(idle), 24'(n.idle), "idle level");
		end
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 60000) begin
			fails++;
			give_verdict();
		end
		if (conv_start) begin
			if (conv_q.size() == 0) chk(24'h000001, 24'h000000, "stray conversion");
			else chk(24'(conv_rate), 24'(conv_q.pop_front()), "rate");
		end
		if (cal_start) begin
			if (cal_q.size() == 0) chk(24'h000001, 24'h000000, "stray calibration");
			else chk(24'(cal_kind), 24'(cal_q.pop_front()), "calibration kind");
		end
	end
	initial begin
		regs_m = '{24'(`RST_STATUS), 24'(`RST_CONTROL_REGISTER_ONE), 24'(`RST_PIN_CONTROL_REGISTER), 24'(`RST_GAIN_CAL_CONTROL_REGISTER),
			`RST_WIDE, `RST_WIDE, `RST_WIDE, `RST_WIDE, `RST_WIDE};
		sample_valid = 1'b0;
		sample = 16'h0000;
		sample_over = 1'b0;
		sample_under = 1'b0;
		cal_overrange = 1'b0;
		gpio_in = 4'(rnd());
		repeat (16) @(negedge mclk);
		srst = 1'b0;
		repeat (4) @(negedge mclk);
		for (int i = 0; i < 9; i++) rd(i);
		rd(1, 2);
		for (int i = 0; i < 9; i++) wr(i, 24'(rnd()));
		chk({gpio_oe, gpio_out, control_register_one_q, gain_cal_control_register_q},
			{regs_m[2][7:0], regs_m[1][7:0], regs_m[3][7:0]}, "config pins");
		for (int i = 0; i < 9; i++) rd(i);
		u_spi_host_model.xfer(0, 8'hE2, 8, 24'h0000FF, 1'b0);
		rd(1);
		cmd(8'h88);
		chk(24'(power_down), 24'h000001, "power down");
		for (int r = 0; r < 8; r++) begin
			if (r == 4) wr(3, 24'(rnd()));
			conv_q.push_back(3'(r));
			cmd({5'b10000, 3'(r)});
			busy_m = 1'b1;
			rate_m = 3'(r);
			if (got_m) rdy_m = 1'b0;
			got_m = 1'b0;
			chk(24'(power_down), 24'h000000, "power up");
			rd(0);
			conv_done(16'(rnd()), 1'(rnd()), 1'(rnd()));
			rd(0);
			if (r != 3) rd(4);
		end
		for (int k = 1; k < 4; k++) begin
			cal_q.push_back(2'(k));
			@(negedge mclk);
			cal_overrange = 1'(rnd());
			cmd({2'b10, 2'(k), 4'h0});
			busy_m = 1'b1;
			rd(0);
			repeat (k == 1 ? SELF_CYC : SYS_CYC) @(posedge mclk);
			busy_m = 1'b0;
			if (k > 1) system_gain_overrange_m = cal_overrange;
			rd(0);
		end
		chk(24'(rd_q.size()), 24'h000000, "unread notes");
		give_verdict();
	end
endmodule
